// ### fcc_consts.vh
// Constants for the five channel counter timer block.
// How it works
// - Three bit gating: none, previous terminal count, neighbour/own gate levels, own edges.
// - Edge bit chooses counting on rising (0) or falling (1) source edge.
// - Four bit source: previous terminal count, sources, gates, five timebase taps.
// - Special gate bit: when set, an active gate edge reloads the counter.
// - Reload from load register, or alternately load and hold when option set.
// - Count once then disarm, or keep counting repetitively after terminal count.
// - Count in plain binary or in binary coded decimal.
// - Direction bit: 0 counts down, 1 counts up.
// - Output codes: low, high pulse, toggle, high impedance, low pulse; 3 illegal.
// - Multi-counter command carries five select bits, acts on all selected together.
// - Commands: arm, load, load and arm, disarm and save, latch, disarm.
// - A disarmed counter ignores its source and gate until armed again.
// - Latch copies selected counts into hold registers; counting goes on.
// - Disarm and save stops selected counters and copies count to hold.
// - Unselected counters are left entirely untouched by a command.
// - Load register writes never touch the counter; load commands, terminal count and special gate edges copy it in.
// - Load and arm starts all selected counters in the same cycle.
// - Load registers hold a full sixteen bit value.
// - No direct read of a live counter; read the hold register instead.
// - Timebase taps: 1 MHz, 100 kHz, 10 kHz, 1 kHz, 100 Hz by decades.
// - Host data path is eight bits; sixteen bit values take two bytes.
`ifndef FCC_CONSTS_VH
`define FCC_CONSTS_VH

`define FCC_ADDR_DATA     2'h0
`define FCC_ADDR_PTR      2'h1
`define FCC_ADDR_CMD      2'h2
`define FCC_ADDR_STAT     2'h3

`define FCC_PTR_GRP       4:3
`define FCC_PTR_CTR       2:0
`define FCC_GRP_MODE      2'h0
`define FCC_GRP_LOAD      2'h1
`define FCC_GRP_HOLD      2'h2

`define FCC_CMD_CODE      7:5
`define FCC_CMD_SEL       4:0
`define FCC_CMD_ARM       3'h1
`define FCC_CMD_LOAD      3'h2
`define FCC_CMD_LDARM     3'h3
`define FCC_CMD_SAVE      3'h4
`define FCC_CMD_LATCH     3'h5
`define FCC_CMD_DISARM    3'h6

`define FCC_M_GATE        15:13
`define FCC_M_EDGE        12
`define FCC_M_SRC         11:8
`define FCC_M_SPECIAL     7
`define FCC_M_ALT         6
`define FCC_M_REPEAT      5
`define FCC_M_BCD         4
`define FCC_M_UP          3
`define FCC_M_OUT         2:0

`define FCC_GT_NONE       3'h0
`define FCC_GT_PREV_TC    3'h1
`define FCC_GT_NEXT_HI    3'h2
`define FCC_GT_PREV_HI    3'h3
`define FCC_GT_OWN_HI     3'h4
`define FCC_GT_OWN_LO     3'h5
`define FCC_GT_OWN_RISE   3'h6
`define FCC_GT_OWN_FALL   3'h7

`define FCC_OUT_LOW       3'h0
`define FCC_OUT_PULSE_HI  3'h1
`define FCC_OUT_TOGGLE    3'h2
`define FCC_OUT_HIZ       3'h4
`define FCC_OUT_PULSE_LO  3'h5

`define FCC_ZERO16        16'h0000
`define FCC_BIN_MAX       16'hFFFF
`define FCC_BCD_MAX       16'h9999
`define FCC_BCD_DIGIT_MAX 4'h9
`define FCC_BCD_DIGITS    4
`define FCC_ZERO8         8'h00
`define FCC_MODE_RST      16'h0000

`define FCC_CLK_HZ        40000000
`define FCC_XTAL_HZ       1000000
`define FCC_HALF_CNT      ((`FCC_CLK_HZ) / (2 * (`FCC_XTAL_HZ)))
`define FCC_DECADE_LAST   4'h9

`endif

// ### fcc_counter_timer.v
// Five channel 16-bit counter timer with decade timebase and byte host port.
`default_nettype none
`include "fcc_consts.vh"

module fcc_counter_timer #(
    parameter NUM_CTR = 5
) (
    input  wire       I_REF_CLK,
    input  wire       I_SYS_RST,
    input  wire [1:0] I_ADDR,
    input  wire [7:0] I_WR_DATA,
    input  wire       I_WR_STB,
    input  wire       I_RD_STB,
    output reg  [7:0] O_RD_DATA,
    input  wire [4:0] I_SRC,
    input  wire [4:0] I_GATE,
    output reg  [4:0] O_CNT_OUT,
    output reg  [4:0] O_CNT_OE_N
);

    // The prescaler end count is cut to eight bits on purpose; it is small.
    localparam integer HALF_LAST_I = `FCC_HALF_CNT - 1;
    localparam [7:0]   HALF_LAST   = HALF_LAST_I[7:0];

    // Pin synchronisers; only the second stage is read by logic.
    reg  [4:0]  src_m_reg;
    reg  [4:0]  src_s_reg;
    reg  [4:0]  gate_m_reg;
    reg  [4:0]  gate_s_reg;

    // Timebase.
    reg  [7:0]  pre_reg;
    reg  [3:0]  dec_reg [0:4];
    reg  [4:0]  tap_reg;
    reg  [5:0]  tick;

    // Host port state.
    reg  [4:0]  ptr_reg;
    reg         byte_hi_reg;

    // Per counter state.
    reg  [15:0] mode_reg      [0:4];
    reg  [15:0] load_reg      [0:4];
    reg  [15:0] hold_reg      [0:4];
    reg  [15:0] cnt_reg       [0:4];
    reg  [15:0] cnt_next      [0:4];
    reg  [15:0] hold_next     [0:4];
    reg  [4:0]  armed_reg;
    reg  [4:0]  armed_next;
    reg  [4:0]  src_last_reg;
    reg  [4:0]  gate_last_reg;
    reg  [4:0]  gok_last_reg;
    reg  [4:0]  gate_run_reg;
    reg  [4:0]  gate_run_next;
    reg  [4:0]  use_hold_reg;
    reg  [4:0]  use_hold_next;
    reg  [4:0]  tog_reg;
    reg  [4:0]  tc_reg;
    reg  [4:0]  tc_now;
    reg  [4:0]  src_lvl;
    reg  [4:0]  gate_ok;
    reg  [4:0]  gate_act_edge;
    reg  [4:0]  out_next;
    reg  [4:0]  oe_n_next;

    wire        cmd_wr  = I_WR_STB && (I_ADDR == `FCC_ADDR_CMD);
    wire [2:0]  cmd     = I_WR_DATA[`FCC_CMD_CODE];
    wire [4:0]  cmd_sel = cmd_wr ? I_WR_DATA[`FCC_CMD_SEL] : 5'h00;
    wire [2:0]  ptr_ctr = ptr_reg[`FCC_PTR_CTR];
    wire [1:0]  ptr_grp = ptr_reg[`FCC_PTR_GRP];
    wire        ptr_ok  = (ptr_ctr >= 3'h1) && (ptr_ctr <= 3'h5);
    wire [2:0]  ptr_idx = ptr_ctr - 3'h1;
    wire        data_wr = I_WR_STB && (I_ADDR == `FCC_ADDR_DATA) && ptr_ok;

    // One BCD or binary count step in the chosen direction.
    function [15:0] step_val;
        input [15:0] v;
        input        up;
        input        bcd;
        integer      k;
        reg          carry;
        reg   [3:0]  d;
        begin
            step_val = v;
            carry = 1'b1;
            if (!bcd)
            begin
                step_val = up ? v + 16'h0001 : v - 16'h0001;
            end
            else
            begin
                for (k = 0; k < `FCC_BCD_DIGITS; k = k + 1)
                begin
                    d = v[4*k +: 4];
                    if (carry)
                    begin
                        if (up)
                        begin
                            if (d >= `FCC_BCD_DIGIT_MAX)
                                d = 4'h0;
                            else
                            begin
                                d = d + 4'h1;
                                carry = 1'b0;
                            end
                        end
                        else
                        begin
                            if (d == 4'h0)
                                d = `FCC_BCD_DIGIT_MAX;
                            else
                            begin
                                d = d - 4'h1;
                                carry = 1'b0;
                            end
                        end
                    end
                    step_val[4*k +: 4] = d;
                end
            end
        end
    endfunction

    // Decade chain: each tap toggles on its half-period tick.
    integer t;
    always @*
    begin
        tick[0] = (pre_reg == HALF_LAST);
        for (t = 0; t < 5; t = t + 1)
            tick[t+1] = tick[t] && (dec_reg[t] == `FCC_DECADE_LAST);
    end

    integer i;
    always @*
    begin : ctr_next
        reg [15:0] m;
        reg [15:0] svec;
        reg        edge_ev;
        reg        ev;
        reg        term;
        m = `FCC_MODE_RST;
        svec = `FCC_ZERO16;
        edge_ev = 1'b0;
        ev = 1'b0;
        term = 1'b0;
        for (i = 0; i < NUM_CTR; i = i + 1)
        begin
            m = mode_reg[i];
            svec = {tap_reg, gate_s_reg, src_s_reg, tc_reg[(i+4)%5]};
            src_lvl[i] = svec[m[`FCC_M_SRC]];
            edge_ev = m[`FCC_M_EDGE] ? (src_last_reg[i] & ~src_lvl[i])
                                     : (~src_last_reg[i] & src_lvl[i]);
            case (m[`FCC_M_GATE])
                `FCC_GT_NONE:     gate_ok[i] = 1'b1;
                `FCC_GT_PREV_TC:  gate_ok[i] = tc_reg[(i+4)%5];
                `FCC_GT_NEXT_HI:  gate_ok[i] = gate_s_reg[(i+1)%5];
                `FCC_GT_PREV_HI:  gate_ok[i] = gate_s_reg[(i+4)%5];
                `FCC_GT_OWN_HI:   gate_ok[i] = gate_s_reg[i];
                `FCC_GT_OWN_LO:   gate_ok[i] = ~gate_s_reg[i];
                default:          gate_ok[i] = gate_run_reg[i];
            endcase
            // Edge gates run from the chosen gate edge to terminal count.
            gate_run_next[i] = gate_run_reg[i];
            if (m[`FCC_M_GATE] == `FCC_GT_OWN_RISE)
                gate_act_edge[i] = gate_s_reg[i] & ~gate_last_reg[i];
            else if (m[`FCC_M_GATE] == `FCC_GT_OWN_FALL)
                gate_act_edge[i] = ~gate_s_reg[i] & gate_last_reg[i];
            else
                gate_act_edge[i] = gate_ok[i] & ~gok_last_reg[i];
            if (armed_reg[i] && gate_act_edge[i])
                gate_run_next[i] = 1'b1;
            ev = armed_reg[i] & gate_ok[i] & edge_ev;
            if (m[`FCC_M_UP])
                term = (cnt_reg[i] == (m[`FCC_M_BCD] ? `FCC_BCD_MAX
                                                     : `FCC_BIN_MAX));
            else
                term = (cnt_reg[i] == `FCC_ZERO16);
            tc_now[i] = ev & term;
            cnt_next[i] = cnt_reg[i];
            hold_next[i] = hold_reg[i];
            armed_next[i] = armed_reg[i];
            use_hold_next[i] = use_hold_reg[i];
            if (tc_now[i])
            begin
                gate_run_next[i] = 1'b0;
                if (m[`FCC_M_ALT] && use_hold_reg[i])
                    cnt_next[i] = hold_reg[i];
                else
                    cnt_next[i] = load_reg[i];
                use_hold_next[i] = m[`FCC_M_ALT] & ~use_hold_reg[i];
                if (!m[`FCC_M_REPEAT])
                    armed_next[i] = 1'b0;
            end
            else if (ev)
                cnt_next[i] = step_val(cnt_reg[i], m[`FCC_M_UP],
                                       m[`FCC_M_BCD]);
            // Special gate restarts the count from the load register.
            if (m[`FCC_M_SPECIAL] && armed_reg[i] && gate_act_edge[i])
                cnt_next[i] = load_reg[i];
            if (data_wr && byte_hi_reg && ptr_idx == i
                && ptr_grp == `FCC_GRP_HOLD)
                hold_next[i] = {I_WR_DATA, hold_reg[i][7:0]};
            else if (data_wr && ptr_idx == i && ptr_grp == `FCC_GRP_HOLD)
                hold_next[i] = {hold_reg[i][15:8], I_WR_DATA};
            // Commands override counting but only for selected counters.
            if (cmd_sel[i])
            begin
                case (cmd)
                    `FCC_CMD_ARM:
                        armed_next[i] = 1'b1;
                    `FCC_CMD_LOAD:
                        cnt_next[i] = load_reg[i];
                    `FCC_CMD_LDARM:
                    begin
                        cnt_next[i] = load_reg[i];
                        armed_next[i] = 1'b1;
                    end
                    `FCC_CMD_SAVE:
                    begin
                        hold_next[i] = cnt_reg[i];
                        cnt_next[i] = cnt_reg[i];
                        armed_next[i] = 1'b0;
                    end
                    `FCC_CMD_LATCH:
                        hold_next[i] = cnt_reg[i];
                    `FCC_CMD_DISARM:
                    begin
                        cnt_next[i] = cnt_reg[i];
                        armed_next[i] = 1'b0;
                    end
                    default:
                        armed_next[i] = armed_reg[i];
                endcase
                use_hold_next[i] = (cmd == `FCC_CMD_LOAD
                                    || cmd == `FCC_CMD_LDARM)
                                   ? 1'b0 : use_hold_next[i];
            end
            case (m[`FCC_M_OUT])
                `FCC_OUT_PULSE_HI:
                begin
                    out_next[i] = tc_now[i];
                    oe_n_next[i] = 1'b0;
                end
                `FCC_OUT_TOGGLE:
                begin
                    out_next[i] = tog_reg[i] ^ tc_now[i];
                    oe_n_next[i] = 1'b0;
                end
                `FCC_OUT_HIZ:
                begin
                    out_next[i] = 1'b0;
                    oe_n_next[i] = 1'b1;
                end
                `FCC_OUT_PULSE_LO:
                begin
                    out_next[i] = ~tc_now[i];
                    oe_n_next[i] = 1'b0;
                end
                default:
                begin
                    // Illegal code 3 is treated like code 0.
                    out_next[i] = 1'b0;
                    oe_n_next[i] = 1'b0;
                end
            endcase
        end
    end

    integer n;
    always @(posedge I_REF_CLK)
    begin
        src_m_reg <= I_SRC;
        src_s_reg <= src_m_reg;
        gate_m_reg <= I_GATE;
        gate_s_reg <= gate_m_reg;
        if (I_SYS_RST)
        begin
            pre_reg <= 8'h00;
            tap_reg <= 5'h00;
            ptr_reg <= 5'h00;
            byte_hi_reg <= 1'b0;
            armed_reg <= 5'h00;
            src_last_reg <= 5'h00;
            gate_last_reg <= 5'h00;
            gok_last_reg <= 5'h00;
            gate_run_reg <= 5'h00;
            use_hold_reg <= 5'h00;
            tog_reg <= 5'h00;
            tc_reg <= 5'h00;
            O_RD_DATA <= `FCC_ZERO8;
            O_CNT_OUT <= 5'h00;
            O_CNT_OE_N <= 5'h00;
            for (n = 0; n < NUM_CTR; n = n + 1)
            begin
                dec_reg[n] <= 4'h0;
                mode_reg[n] <= `FCC_MODE_RST;
                load_reg[n] <= `FCC_ZERO16;
                hold_reg[n] <= `FCC_ZERO16;
                cnt_reg[n] <= `FCC_ZERO16;
            end
        end
        else
        begin
            pre_reg <= tick[0] ? 8'h00 : pre_reg + 8'h01;
            for (n = 0; n < 5; n = n + 1)
            begin
                if (tick[n])
                begin
                    tap_reg[n] <= ~tap_reg[n];
                    dec_reg[n] <= tick[n+1] ? 4'h0 : dec_reg[n] + 4'h1;
                end
            end
            armed_reg <= armed_next;
            src_last_reg <= src_lvl;
            gate_last_reg <= gate_s_reg;
            gok_last_reg <= gate_ok;
            gate_run_reg <= gate_run_next;
            use_hold_reg <= use_hold_next;
            tog_reg <= tog_reg ^ tc_now;
            tc_reg <= tc_now;
            O_CNT_OUT <= out_next;
            O_CNT_OE_N <= oe_n_next;
            for (n = 0; n < NUM_CTR; n = n + 1)
            begin
                cnt_reg[n] <= cnt_next[n];
                hold_reg[n] <= hold_next[n];
            end
            // Pointer write restarts byte order at the low byte.
            if (I_WR_STB && I_ADDR == `FCC_ADDR_PTR)
            begin
                ptr_reg <= I_WR_DATA[4:0];
                byte_hi_reg <= 1'b0;
            end
            else if ((I_WR_STB || I_RD_STB) && I_ADDR == `FCC_ADDR_DATA
                     && ptr_ok)
                byte_hi_reg <= ~byte_hi_reg;
            if (data_wr && ptr_grp == `FCC_GRP_MODE)
            begin
                if (byte_hi_reg)
                    mode_reg[ptr_idx] <= {I_WR_DATA, mode_reg[ptr_idx][7:0]};
                else
                    mode_reg[ptr_idx] <= {mode_reg[ptr_idx][15:8], I_WR_DATA};
            end
            if (data_wr && ptr_grp == `FCC_GRP_LOAD)
            begin
                if (byte_hi_reg)
                    load_reg[ptr_idx] <= {I_WR_DATA, load_reg[ptr_idx][7:0]};
                else
                    load_reg[ptr_idx] <= {load_reg[ptr_idx][15:8], I_WR_DATA};
            end
            // The live count has no read path at all.
            if (!I_RD_STB)
                O_RD_DATA <= `FCC_ZERO8;
            else if (I_ADDR == `FCC_ADDR_PTR)
                O_RD_DATA <= {3'h0, ptr_reg};
            else if (I_ADDR == `FCC_ADDR_STAT)
                O_RD_DATA <= {3'h0, armed_reg};
            else if (I_ADDR == `FCC_ADDR_DATA && ptr_ok
                     && ptr_grp == `FCC_GRP_MODE)
                O_RD_DATA <= byte_hi_reg ? mode_reg[ptr_idx][15:8]
                                         : mode_reg[ptr_idx][7:0];
            else if (I_ADDR == `FCC_ADDR_DATA && ptr_ok
                     && ptr_grp == `FCC_GRP_LOAD)
                O_RD_DATA <= byte_hi_reg ? load_reg[ptr_idx][15:8]
                                         : load_reg[ptr_idx][7:0];
            else if (I_ADDR == `FCC_ADDR_DATA && ptr_ok
                     && ptr_grp == `FCC_GRP_HOLD)
                O_RD_DATA <= byte_hi_reg ? hold_reg[ptr_idx][15:8]
                                         : hold_reg[ptr_idx][7:0];
            else
                O_RD_DATA <= `FCC_ZERO8;
        end
    end

endmodule
`default_nettype wire

// ### fcc_counter_timer_chk.sv
// Checker of the counter timer host port and output pins.
`default_nettype none
module fcc_counter_timer_chk #(
    parameter NUM_CTR = 5
) (
    input wire logic       I_REF_CLK,
    input wire logic       I_SYS_RST,
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WR_DATA,
    input wire logic       I_WR_STB,
    input wire logic       I_RD_STB,
    input wire logic [7:0] O_RD_DATA,
    input wire logic [4:0] I_SRC,
    input wire logic [4:0] I_GATE,
    input wire logic [4:0] O_CNT_OUT,
    input wire logic [4:0] O_CNT_OE_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ptr_q;
    logic       none_q;
    logic       none_nx;
    logic [2:0] code;
    logic [4:0] sel;
    assign code = I_WR_DATA[7:5];
    assign sel = I_WR_DATA[4:0];
    // Only a disarm of all five proves the block idle; arming clears it.
    assign none_nx = (sel == 5'h1f && (code == 3'h4 || code == 3'h6))
        || (none_q && (sel == 5'h00 || (code >= 3'h2 && code <= 3'h6
        && code != 3'h3)));
    always @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            ptr_q <= 8'h00;
            none_q <= 1'b1;
        end
        else if (I_WR_STB && I_ADDR == 2'h1)
            ptr_q <= I_WR_DATA;
        else if (I_WR_STB && I_ADDR == 2'h2)
            none_q <= none_nx;
    end
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_rd_quiet_zero: assert property (!$past(I_RD_STB) |->
        O_RD_DATA == 8'h00) else $error("read data outside its cycle");
    a_cmd_rd_zero: assert property (
        $past(I_RD_STB && I_ADDR == 2'h2) |-> O_RD_DATA == 8'h00)
        else $error("command port read not zero");
    a_stat_top_zero: assert property (
        $past(I_RD_STB && I_ADDR == 2'h3) |->
        (O_RD_DATA >> NUM_CTR) == 8'h00)
        else $error("status bit beyond last counter");
    a_bad_ptr_zero: assert property ($past(I_RD_STB &&
        I_ADDR == 2'h0 && !(ptr_q[2:0] inside {[1:5]})) |->
        O_RD_DATA == 8'h00) else $error("read of no counter not zero");
    a_oe_after_write: assert property ($changed(O_CNT_OE_N) |->
        $past(I_WR_STB) || $past(I_WR_STB, 2) || $past(I_WR_STB, 3))
        else $error("output enable moved without a write");
    a_reset_idle_out: assert property ($fell(I_SYS_RST) |->
        O_CNT_OUT == 5'h00 && O_CNT_OE_N == 5'h00 && O_RD_DATA == 8'h00)
        else $error("outputs not idle after reset");
    a_stat_none_armed: assert property (
        $past(I_RD_STB && I_ADDR == 2'h3 && none_q) |->
        O_RD_DATA == 8'h00) else $error("counter armed after disarm");
    a_out_quiet_idle: assert property (none_q && $past(none_q)
        && $past(none_q, 2) && !$past(I_WR_STB) && !$past(I_WR_STB, 2)
        && !$past(I_WR_STB, 3) |-> $stable(O_CNT_OUT))
        else $error("disarmed counter output moved");
endmodule
bind fcc_counter_timer fcc_counter_timer_chk #(.NUM_CTR(NUM_CTR)) u_chk (
    .I_REF_CLK  (I_REF_CLK),
    .I_SYS_RST  (I_SYS_RST),
    .I_ADDR     (I_ADDR),
    .I_WR_DATA  (I_WR_DATA),
    .I_WR_STB   (I_WR_STB),
    .I_RD_STB   (I_RD_STB),
    .O_RD_DATA  (O_RD_DATA),
    .I_SRC      (I_SRC),
    .I_GATE     (I_GATE),
    .O_CNT_OUT  (O_CNT_OUT),
    .O_CNT_OE_N (O_CNT_OE_N)
);
`default_nettype wire

// ### fcc_pin_drv.sv
// Model of the signals wired to the counter source and gate pins.
`default_nettype none
module fcc_pin_drv (
    input  wire logic       i_clk,
    output var  logic [4:0] o_src,
    output var  logic [4:0] o_gate
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_src = 5'h00;
        o_gate = 5'h00;
    end
    // Each level holds four clocks, so the two stage synchroniser sees it.
    task automatic pulse(input logic [4:0] s, input logic [4:0] g,
                         input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            o_src <= s;
            o_gate <= g;
            repeat (4) @(posedge i_clk);
            o_src <= 5'h00;
            o_gate <= 5'h00;
            repeat (4) @(posedge i_clk);
        end
    endtask
endmodule
`default_nettype wire

// ### fcc_counter_timer_tb.sv
// Self-checking testbench of the five channel counter timer.
`default_nettype none
module fcc_counter_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [1:0]      addr = 2'h0;
    logic [7:0]      wdat = 8'h00;
    logic            wstb = 1'b0;
    logic            rstb = 1'b0;
    wire logic [7:0] rdat;
    wire logic [4:0] src;
    wire logic [4:0] gate;
    wire logic [4:0] cout;
    wire logic [4:0] oen;
    int              n_fail = 0;
    int              total_checks = 0;
    int              npulse = 0;
    logic            prev_out = 1'b0;
    logic [7:0]      d;

    always #12.5 clk = ~clk;

    fcc_counter_timer DUT (
        .I_REF_CLK  (clk),
        .I_SYS_RST  (rst),
        .I_ADDR     (addr),
        .I_WR_DATA  (wdat),
        .I_WR_STB   (wstb),
        .I_RD_STB   (rstb),
        .O_RD_DATA  (rdat),
        .I_SRC      (src),
        .I_GATE     (gate),
        .O_CNT_OUT  (cout),
        .O_CNT_OE_N (oen)
    );
    fcc_pin_drv PIN (
        .i_clk  (clk),
        .o_src  (src),
        .o_gate (gate)
    );

    always @(posedge clk)
    begin
        prev_out <= cout[0];
        if (cout[0] === 1'b1 && prev_out === 1'b0)
            npulse <= npulse + 1;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdat <= v;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 v = rdat;
    endtask
    // Sixteen bit values cross the byte port low byte first.
    task automatic w16(input logic [7:0] p, input logic [15:0] v);
        wr(2'h1, p);
        wr(2'h0, v[7:0]);
        wr(2'h0, v[15:8]);
    endtask
    task automatic hold(input logic [2:0] c, input logic [15:0] e);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(2'h1, {5'h02, c});
        rd(2'h0, lo);
        rd(2'h0, hi);
        chk("hold", e, {hi, lo});
    endtask
    task automatic cmd(input logic [2:0] c, input logic [4:0] s);
        wr(2'h2, {c, s});
    endtask
    task automatic stat(input logic [7:0] e);
        logic [7:0] v;
        rd(2'h3, v);
        chk("status", {8'h00, e}, {8'h00, v});
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run;
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        stat(8'h00);
        chk("oe", 16'h0000, {11'h000, oen});
        wr(2'h1, 8'h10);
        rd(2'h0, d);
        chk("bad ptr", 16'h0000, {8'h00, d});
        rd(2'h2, d);
        chk("cmd rd", 16'h0000, {8'h00, d});
        // Counter 1: pin 1 source, repeat, high pulse; code 3 never used.
        w16(8'h01, 16'h0121);
        w16(8'h09, 16'h0005);
        cmd(3'h5, 5'h01);
        hold(3'h1, 16'h0000);
        cmd(3'h2, 5'h01);
        cmd(3'h5, 5'h01);
        hold(3'h1, 16'h0005);
        cmd(3'h1, 5'h01);
        stat(8'h01);
        PIN.pulse(5'h01, 5'h00, 3);
        cmd(3'h5, 5'h01);
        hold(3'h1, 16'h0002);
        stat(8'h01);
        PIN.pulse(5'h01, 5'h00, 3);
        chk("tc pulses", 16'h0001, npulse[15:0]);
        cmd(3'h5, 5'h01);
        hold(3'h1, 16'h0005);
        // Counter 2 counts gate 2 in decimal, counter 3 counts pin 3.
        w16(8'h02, 16'h0718);
        w16(8'h0a, 16'h0009);
        w16(8'h03, 16'h0308);
        w16(8'h0b, 16'h7fff);
        cmd(3'h3, 5'h06);
        stat(8'h07);
        PIN.pulse(5'h04, 5'h02, 1);
        cmd(3'h5, 5'h06);
        hold(3'h2, 16'h0010);
        hold(3'h3, 16'h8000);
        PIN.pulse(5'h01, 5'h00, 1);
        cmd(3'h4, 5'h01);
        stat(8'h06);
        hold(3'h1, 16'h0004);
        PIN.pulse(5'h01, 5'h00, 2);
        cmd(3'h5, 5'h03);
        hold(3'h1, 16'h0004);
        hold(3'h2, 16'h0010);
        // Counter 4: pin 4 rises gated by gate 4, alternate reload, toggle.
        // Counter 5: pin 5 falls, counts once and stops, low pulse output.
        w16(8'h04, 16'h8462);
        w16(8'h0c, 16'h0001);
        w16(8'h05, 16'h1505);
        w16(8'h0d, 16'h0000);
        cmd(3'h3, 5'h18);
        // The status read lands after the rise and before the fall.
        fork
            PIN.pulse(5'h18, 5'h00, 1);
            begin
                repeat (3) @(posedge clk);
                stat(8'h1e);
            end
        join
        stat(8'h0e);
        cmd(3'h5, 5'h08);
        hold(3'h4, 16'h0001);
        w16(8'h14, 16'h0007);
        PIN.pulse(5'h08, 5'h08, 2);
        chk("toggle", 16'h0001, {15'h0000, cout[3]});
        PIN.pulse(5'h08, 5'h08, 2);
        cmd(3'h5, 5'h08);
        hold(3'h4, 16'h0007);
        chk("toggle", 16'h0000, {15'h0000, cout[3]});
        w16(8'h01, 16'h0124);
        repeat (3) @(posedge clk);
        chk("oe", 16'h0001, {11'h000, oen});
        cmd(3'h6, 5'h1f);
        stat(8'h00);
        complete_run;
    end
endmodule
`default_nettype wire
